/* File: rtl/cums_map.vh */
// Register map and timing constants of the smart-card UART mixed status register.
// Included by the status block; holds definitions only.
`ifndef CUMS_MAP_VH
`define CUMS_MAP_VH
`define CUMS_ADDR_W           4
`define CUMS_MIXED_STATUS_OFF 4'hc
`define CUMS_BIT_CLOCK_SWITCH_DONE_DONE   7
`define CUMS_BIT_RX_EMPTY     6
`define CUMS_BIT_BGUARD       5
`define CUMS_BIT_CARD_PRES    2
`define CUMS_BIT_BUF_READY    0
`define CUMS_RST_RX_EMPTY     1'b1
`define CUMS_RST_BGUARD       1'b0
`define CUMS_BGT_T1_ETU       5'h16
`define CUMS_BGT_T0_ETU       5'h10
`endif

/* File: rtl/cums_status.v */
// Mixed status register of a smart-card UART, read-only over classic Wishbone.
// Assumes the UART core supplies one-cycle event pulses and an ETU enable on clk_i.
// Behaviour
// - Clock switch done sets after switch to half clock, clears after switch back.
// - Clock switch done clears at reset and while UART reset control asserted.
// - FIFO empty flag is high while receive FIFO holds no character.
// - In T=1, 22 ETU counter restarts on start bit, sets guard flag.
// - In T=0, 16 ETU counter restarts on start bit, sets guard flag.
// - Bit 2 reads one while a card is present.
// - Buffer ready flag sets on change from reception to transmission.
// - Buffer ready flag sets after each sent character, except clean with last-char.
// - Buffer ready flag clears on reset, tx write, rx read, tx-to-rx change.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
`include "cums_map.vh"
module cums_status (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [7:0]  wb_dat_i,
  input  wire        wb_sel_i,
  output reg  [7:0]  wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  input  wire        uart_reset_control_i,
  input  wire        clk_switch_half_done_i,
  input  wire        clk_switch_xtal_done_i,
  input  wire [3:0]  rx_fifo_level_i,
  input  wire        protocol_t1_i,
  input  wire        etu_tick_i,
  input  wire        start_bit_i,
  input  wire        card_present_i,
  input  wire        tx_mode_i,
  input  wire        char_sent_i,
  input  wire        char_sent_parity_ok_i,
  input  wire        last_char_control_i,
  input  wire        tx_holding_reg_write_i,
  input  wire        rx_holding_reg_read_i,
  output reg         clock_switch_done_o,
  output reg         block_guard_elapsed_o
);
  reg        clock_switch_done;
  reg        rx_fifo_empty;
  reg        block_guard_elapsed;
  reg        card_sync1;
  reg        card_present;
  reg        buffer_ready_flag;
  reg        tx_mode_d;
  reg        bgt_running;
  reg  [4:0] bgt_count;
  reg        next_clock_switch_done;
  reg        next_buffer_ready_flag;
  reg        next_bgt_running;
  reg  [4:0] next_bgt_count;
  reg        next_block_guard_elapsed;
  reg        hit;
  reg  [7:0] status_word;
  wire [4:0] bgt_limit;
  wire [4:0] bgt_count_inc;
  wire       bgt_done;
  wire       tx_enter;
  wire       tx_leave;
  wire       buf_set;
  wire       buf_clear;
  wire       sw_rst;
  wire       req;

  assign sw_rst        = rst_i | uart_reset_control_i;
  assign bgt_limit     = protocol_t1_i ? `CUMS_BGT_T1_ETU : `CUMS_BGT_T0_ETU;
  assign bgt_count_inc = bgt_count + 5'h01;
  assign bgt_done      = bgt_running & etu_tick_i & (bgt_count_inc >= bgt_limit);
  assign req           = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign tx_enter      = tx_mode_i & ~tx_mode_d;
  assign tx_leave      = ~tx_mode_i & tx_mode_d;
  assign buf_set       = tx_enter |
                         (char_sent_i & ~(char_sent_parity_ok_i & last_char_control_i));
  assign buf_clear     = tx_holding_reg_write_i | rx_holding_reg_read_i | tx_leave;

  // Only a read of the status offset is answered with ack; the rest get err
  always @* begin
    hit = 1'b0;
    if (wb_we_i) begin
      hit = 1'b0;
    end else if (wb_adr_i == `CUMS_MIXED_STATUS_OFF) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Spare bits stay zero
  always @* begin
    status_word                       = 8'h00;
    status_word[`CUMS_BIT_CLOCK_SWITCH_DONE_DONE] = clock_switch_done;
    status_word[`CUMS_BIT_RX_EMPTY]   = rx_fifo_empty;
    status_word[`CUMS_BIT_BGUARD]     = block_guard_elapsed;
    status_word[`CUMS_BIT_CARD_PRES]  = card_present;
    status_word[`CUMS_BIT_BUF_READY]  = buffer_ready_flag;
  end

  // A half-clock completion wins if both completions arrive together
  always @* begin
    next_clock_switch_done = clock_switch_done;
    if (clk_switch_half_done_i) begin
      next_clock_switch_done = 1'b1;
    end else if (clk_switch_xtal_done_i) begin
      next_clock_switch_done = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (sw_rst) begin
      clock_switch_done <= 1'b0;
    end else begin
      clock_switch_done <= next_clock_switch_done;
    end
  end

  always @(posedge clk_i) begin
    if (sw_rst) begin
      rx_fifo_empty <= `CUMS_RST_RX_EMPTY;
    end else begin
      rx_fifo_empty <= (rx_fifo_level_i == 4'h0);
    end
  end

  // Guard counter: restarts on each start bit, flag sets once count completes
  always @* begin
    next_bgt_running         = bgt_running;
    next_bgt_count           = bgt_count;
    next_block_guard_elapsed = block_guard_elapsed;
    if (start_bit_i) begin
      next_bgt_running         = 1'b1;
      next_bgt_count           = 5'h00;
      next_block_guard_elapsed = 1'b0;
    end else if (bgt_running && etu_tick_i) begin
      next_bgt_count = bgt_count_inc;
      if (bgt_done) begin
        next_bgt_running         = 1'b0;
        next_block_guard_elapsed = 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (sw_rst) begin
      bgt_running         <= 1'b0;
      bgt_count           <= 5'h00;
      block_guard_elapsed <= `CUMS_RST_BGUARD;
    end else begin
      bgt_running         <= next_bgt_running;
      bgt_count           <= next_bgt_count;
      block_guard_elapsed <= next_block_guard_elapsed;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      card_sync1   <= 1'b0;
      card_present <= 1'b0;
    end else begin
      card_sync1   <= card_present_i;
      card_present <= card_sync1;
    end
  end

  // Set wins over clear when both land in one cycle
  always @* begin
    next_buffer_ready_flag = buffer_ready_flag;
    if (buf_set) begin
      next_buffer_ready_flag = 1'b1;
    end else if (buf_clear) begin
      next_buffer_ready_flag = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (sw_rst) begin
      tx_mode_d         <= 1'b0;
      buffer_ready_flag <= 1'b0;
    end else begin
      tx_mode_d         <= tx_mode_i;
      buffer_ready_flag <= next_buffer_ready_flag;
    end
  end

  // Bus slave: one registered ack a cycle after the request, writes and unmapped addresses answer err
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      if (req & hit) begin
        wb_dat_o <= status_word;
      end else begin
        wb_dat_o <= 8'h00;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      clock_switch_done_o   <= 1'b0;
      block_guard_elapsed_o <= 1'b0;
    end else begin
      clock_switch_done_o   <= clock_switch_done;
      block_guard_elapsed_o <= block_guard_elapsed;
    end
  end
endmodule

/* File: testbench/cums_chk_asserts.sv */
// Port assertions for the mixed status block.
// Bound to cums_status; one clock, sync reset.
`timescale 1ns/100ps
module cums_chk (
  input wire       clk_i,
  input wire       rst_i,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire       wb_ack_o,
  input wire       wb_err_o,
  input wire [3:0] wb_adr_i,
  input wire [7:0] wb_dat_o,
  input wire       clk_switch_half_done_i,
  input wire       clk_switch_xtal_done_i,
  input wire       start_bit_i,
  input wire       clock_switch_done_o,
  input wire       block_guard_elapsed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  err_once_a: assert property (wb_err_o |=> !wb_err_o) else $error("err held");
  read_ack_a: assert property (req_s ##0 (!wb_we_i && wb_adr_i == 4'hc) |=> wb_ack_o)
    else $error("no ack");
  bad_req_a: assert property (req_s ##0 (wb_we_i || wb_adr_i != 4'hc) |=> wb_err_o)
    else $error("no err");
  idle_data_a: assert property (!wb_ack_o |-> !wb_dat_o) else $error("stray data");
  spare_bits_a: assert property (wb_ack_o |-> !wb_dat_o[4:3] && !wb_dat_o[1])
    else $error("spare bit");
  clock_switch_done_clr_a: assert property (clk_switch_xtal_done_i && !clk_switch_half_done_i |=> ##1
    !clock_switch_done_o) else $error("switch stuck");
  guard_clr_a: assert property (start_bit_i |-> ##2 !block_guard_elapsed_o)
    else $error("guard stuck");
endmodule
bind cums_status cums_chk chk (.*);

/* File: testbench/cums_mcu.sv */
// Wishbone master standing for the controller; classic single cycles.
// A wait ends after 20 cycles and returns a zero response.
`timescale 1ns/100ps
module cums_mcu (
  input  wire        clk_i,
  input  wire        ack_i,
  input  wire        err_i,
  input  wire  [7:0] dat_i,
  output logic       cyc_o = 1'b0,
  output logic       stb_o = 1'b0,
  output logic       we_o  = 1'b0,
  output logic       sel_o = 1'b0,
  output logic [3:0] adr_o = 4'h0,
  output logic [7:0] dat_o = 8'h00
);
  task xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [9:0] r);
    int n;
    n = 0;
    @(posedge clk_i) {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'h3, w, 1'b1, a, d};
    do @(posedge clk_i); while (!ack_i && !err_i && ++n < 20);
    r = {err_i, ack_i, dat_i};
    {cyc_o, stb_o, sel_o} <= 3'h0;
  endtask
endmodule

/* File: testbench/cums_status_tb_top.sv */
// Bench for the mixed status block: flag rows, then bus, reset and guard cases.
// Bus side driven through cums_mcu; UART-side pulses come from vector p.
`timescale 1ns/100ps
module cums_status_tb_top;
  logic clk_i = 0, rst_i = 1, protocol_t1_i = 0, card_present_i = 1, tx_mode_i = 0;
  logic char_sent_parity_ok_i = 1, last_char_control_i = 0, wb_sel_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, clock_switch_done_o;
  logic block_guard_elapsed_o;
  logic [3:0] rx_fifo_level_i = 0, wb_adr_i;
  logic [7:0] p = 0, wb_dat_i, wb_dat_o;
  wire clk_switch_half_done_i = p[0], clk_switch_xtal_done_i = p[1];
  wire uart_reset_control_i = p[2], start_bit_i = p[3], etu_tick_i = p[4], char_sent_i = p[5];
  wire tx_holding_reg_write_i = p[6], rx_holding_reg_read_i = p[7];
  logic [9:0] v;
  // Row: tx mode, last-char, fifo level, pulse enable, pulse index, expected status
  logic [14:0] rows [12] = '{15'h08c4, 15'h0944, 15'h08c4, 15'h0a44, 15'h1004, 15'h4045,
    15'h4e44, 15'h6d44, 15'h4d45, 15'h4f44, 15'h4d45, 15'h0044};
  int miscompares = 0, samples_checked = 0, t;
  always #50 clk_i = ~clk_i;
  cums_status dut (.*);
  cums_mcu mcu (.clk_i, .ack_i(wb_ack_o), .err_i(wb_err_o), .dat_i(wb_dat_o),
    .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i),
    .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  task ck(input logic [9:0] g, e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask
  task pl(input int i);
    @(posedge clk_i) p[i] <= 1'b1;
    @(posedge clk_i) p[i] <= 1'b0;
  endtask
  // A bus wait that runs out counts as a mismatch and ends the scenarios
  task bus(input logic w, input logic [3:0] a);
    mcu.xfer(w, a, 8'h5a, v);
    if (v[9:8] == 2'h0) begin
      miscompares++;
      $display("bus timeout t=%0t", $time);
      disable scenarios;
    end
  endtask
  task wait_switch(input logic lvl);
    int n;
    for (n = 0; n < 8 && clock_switch_done_o !== lvl; n++) @(posedge clk_i);
    if (clock_switch_done_o !== lvl) begin
      miscompares++;
      $display("switch timeout t=%0t", $time);
      disable scenarios;
    end
  endtask
  task rd(input logic [7:0] e);
    bus(1'b0, 4'hc);
    ck(v, {2'h1, e});
  endtask
  task rs;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    begin : scenarios
      rs;
      rd(8'h44);
      foreach (rows[i]) begin
        {tx_mode_i, last_char_control_i, rx_fifo_level_i[0]} <= rows[i][14:12];
        if (rows[i][11]) pl(rows[i][10:8]);
        rd(rows[i][7:0]);
      end
      // Parity error with last-char set still sets, and beats a same-cycle clear
      {tx_mode_i, last_char_control_i, char_sent_parity_ok_i} <= 3'b110;
      pl(6);
      rd(8'h44);
      @(posedge clk_i) p <= 8'h60;
      @(posedge clk_i) p <= 8'h00;
      rd(8'h45);
      {tx_mode_i, last_char_control_i, char_sent_parity_ok_i} <= 3'b001;
      $display("flag rows done");
      bus(1'b1, 4'hc);
      ck(v, 10'h200);
      bus(1'b0, 4'h4);
      ck(v, 10'h200);
      pl(0);
      wait_switch(1'b1);
      ck({9'h0, clock_switch_done_o}, 10'h1);
      rs;
      ck({9'h0, clock_switch_done_o}, 10'h0);
      rd(8'h44);
      card_present_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(8'h40);
      $display("bus and reset done");
      for (t = 0; t < 2; t++) begin
        protocol_t1_i <= t[0];
        pl(3);
        repeat (t ? 21 : 15) pl(4);
        repeat (3) @(posedge clk_i);
        ck({9'h0, block_guard_elapsed_o}, 10'h0);
        pl(4);
        repeat (3) @(posedge clk_i);
        ck({9'h0, block_guard_elapsed_o}, 10'h1);
      end
      $display("guard done");
    end
    complete_run;
  end
endmodule
